// >>> hdl/mdc_pkg.sv
// Constants and types of the multichannel DMA control block.
// Assumes a 16-bit data space and one system clock.
package mdc_pkg;
    // Register byte offsets.
    localparam logic [11:0] GCTRL_OFF = 12'h000;
    localparam logic [11:0] ULIM_OFF = 12'h004;
    localparam logic [11:0] LLIM_OFF = 12'h008;
    localparam logic [11:0] DBUF_OFF = 12'h00c;
    localparam logic [11:0] CH_BASE = 12'h020;
    localparam int CH_SHIFT = 5;
    localparam logic [4:0] CCTRL_OFF = 5'h00;
    localparam logic [4:0] CINT_OFF = 5'h04;
    localparam logic [4:0] CSRC_OFF = 5'h08;
    localparam logic [4:0] CDST_OFF = 5'h0c;
    localparam logic [4:0] CCNT_OFF = 5'h10;
    // Field positions and masks.
    localparam int G_EN = 15;
    localparam int G_PRS = 0;
    localparam logic [15:0] G_WMASK = 16'h8001;
    localparam int C_NULL_WRITE_MODE = 10;
    localparam int C_RELOAD = 9;
    localparam int C_REQ = 8;
    localparam int C_SAM = 6;
    localparam int C_DAM = 4;
    localparam int C_TRM = 2;
    localparam int C_SIZE = 1;
    localparam int C_EN = 0;
    localparam logic [15:0] C_WMASK = 16'h07ff;
    localparam int I_PEND = 15;
    localparam int I_SEL = 8;
    localparam int I_FLG = 3;
    localparam int I_HEN = 0;
    localparam int F_HIGH = 4;
    localparam int F_LOW = 3;
    localparam int F_DONE = 2;
    localparam int F_HALF = 1;
    localparam int F_OVR = 0;
    localparam int TM_REP = 0;
    localparam int TM_CONT = 1;
    localparam logic [1:0] AM_INC = 2'h1;
    localparam logic [1:0] AM_DEC = 2'h2;
    localparam logic [15:0] SFR_TOP = 16'h07ff;
    localparam logic [5:0] TRIG_NONE = 6'h00;
    localparam logic [5:0] TRIG_UNIMPL = 6'h3d;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;

    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE, ST_NULL} mdc_fsm_t;

    typedef struct packed {
        logic [15:0] ctrl;
        logic [5:0] trig;
        logic [4:0] flags;
        logic half_irq_enable;
        logic pend;
        logic [15:0] src;
        logic [15:0] dst;
        logic [15:0] cnt;
        logic [15:0] sSave;
        logic [15:0] dSave;
        logic [15:0] cSave;
        logic busy;
        logic rArm;
    } mdc_chan_t;
endpackage

// >>> hdl/mdc_dma_control.sv
// Multichannel DMA control: registers, triggers, arbitration and mover.
// Assumes an AXI4-Lite master and a data bus that holds memAck for one
// cycle per access; periphEvent bits are one-cycle interrupt pulses.
`timescale 1ns/1ps
// Operation
// RULE1: Engine enable off aborts every channel.
// RULE2: Priority select bit picks round-robin or fixed.
// RULE3: Null write repeats each write at source.
// RULE4: Restore bit reloads pointers on next start.
// RULE5: Repeated modes always reload pointers and count.
// RULE6: Soft request triggers; cleared at completion.
// RULE7: Source mode fixes, increments or decrements pointer.
// RULE8: Destination mode steps its pointer likewise.
// RULE9: Mode field picks one-shot, continuous, repeated.
// RULE10: Size bit picks byte or word, word default.
// RULE11: Channel works only while its enable set.
// RULE12: Pending flag shows buffer not yet written.
// RULE13: Trigger code picks event; unused codes none.
// RULE14: Access above upper limit sets upper flag.
// RULE15: Access below lower limit sets lower flag; code skips addresses up to SFR_TOP (07ff).
// RULE16: Limits are checked only at the access.
// RULE17: Done flag set at completion, cleared running.
// RULE18: Half flag set at counter halfway point.
// RULE19: Trigger while busy sets overrun flag.
// RULE20: Half enable adds halfway interrupt to completion.
// RULE21: Software flag writes raise no interrupt.
// RULE22: Software keeps reserved control bit zero.
// RULE23: Limit violation ends transaction with interrupt.
// RULE24: Fixed lowest wins; round-robin rotates winners.
// RULE25: One-shot one transaction; continuous runs count.
// RULE26: Byte mode address bit selects byte lane.
module mdc_dma_control #(
    parameter int NCH = 6,
    parameter int AW = 12
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // AXI4-Lite register slave.
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Peripheral trigger pulses.
    input wire logic [63:0] periphEvent,
    // Data space access.
    output logic memReq,
    output logic memWe,
    output logic [15:0] memAddr,
    output logic [15:0] memWdata,
    output logic [1:0] memBe,
    input wire logic [15:0] memRdata,
    input wire logic memAck,
    // Channel interrupt pulses.
    output logic [NCH-1:0] chanIrq
);
    localparam int CW = $clog2(NCH);

    typedef struct packed {
        logic [15:0] gctl;
        logic [15:0] ulim;
        logic [15:0] llim;
        logic [15:0] dbuf;
        mdc_pkg::mdc_chan_t [NCH-1:0] ch;
        mdc_pkg::mdc_fsm_t fsm;
        logic [CW-1:0] cur;
        logic [CW-1:0] rrBase;
        logic awHeld;
        logic [AW-1:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [15:0] rdata;
        logic [1:0] rresp;
        logic memReq;
        logic memWe;
        logic [15:0] memAddr;
        logic [15:0] memWdata;
        logic [1:0] memBe;
        logic [NCH-1:0] irq;
    } mdc_state_t;

    mdc_state_t s_reg;
    mdc_state_t s_next;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] mrg(input logic [15:0] o,
                                        input logic [31:0] d,
                                        input logic [3:0] s);
        mrg = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
    endfunction

    function automatic logic [1:0] viol(input logic [15:0] a,
                                        input logic [15:0] u,
                                        input logic [15:0] l);
        viol = {a > u, a > mdc_pkg::SFR_TOP && a < l}; // see RULE14 RULE15
    endfunction

    function automatic logic [1:0] laneBe(input logic byteMode,
                                          input logic a0);
        laneBe = byteMode ? (a0 ? 2'h2 : 2'h1) : 2'h3; // see RULE26
    endfunction

    function automatic logic [15:0] stepPtr(input logic [15:0] p,
                                            input logic [1:0] m,
                                            input logic byteMode);
        logic [15:0] st;
        st = byteMode ? mdc_pkg::STEP_BYTE : mdc_pkg::STEP_WORD; // see RULE10
        if (m == mdc_pkg::AM_INC) begin
            stepPtr = p + st;
        end else if (m == mdc_pkg::AM_DEC) begin
            stepPtr = p - st;
        end else begin
            stepPtr = p;
        end
    endfunction

    function automatic logic [17:0] rdFn(input mdc_state_t s,
                                         input logic [AW-1:0] a);
        int idx;
        logic [4:0] sub;
        mdc_pkg::mdc_chan_t c;
        idx = int'(a >> mdc_pkg::CH_SHIFT) - 1;
        sub = a[mdc_pkg::CH_SHIFT-1:0];
        rdFn = {mdc_pkg::RESP_OKAY, 16'h0000};
        if (a == AW'(mdc_pkg::GCTRL_OFF)) begin
            rdFn[15:0] = s.gctl;
        end else if (a == AW'(mdc_pkg::ULIM_OFF)) begin
            rdFn[15:0] = s.ulim;
        end else if (a == AW'(mdc_pkg::LLIM_OFF)) begin
            rdFn[15:0] = s.llim;
        end else if (a == AW'(mdc_pkg::DBUF_OFF)) begin
            rdFn[15:0] = s.dbuf;
        end else if (idx >= 0 && idx < NCH) begin
            c = s.ch[idx];
            case (sub)
                mdc_pkg::CCTRL_OFF: rdFn[15:0] = c.ctrl;
                mdc_pkg::CINT_OFF: rdFn[15:0] = {c.pend, 1'b0, c.trig,
                                                 c.flags, 2'h0, c.half_irq_enable};
                mdc_pkg::CSRC_OFF: rdFn[15:0] = c.src;
                mdc_pkg::CDST_OFF: rdFn[15:0] = c.dst;
                mdc_pkg::CCNT_OFF: rdFn[15:0] = c.cnt;
                default: rdFn[17:16] = mdc_pkg::RESP_SLVERR;
            endcase
        end else begin
            rdFn[17:16] = mdc_pkg::RESP_SLVERR;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic [NCH-1:0] reqV;
    logic [NCH-1:0] hwTrig;

    always_comb begin
        logic [4:0] fset [NCH];
        logic en;
        logic [5:0] code;
        logic found;
        int w;
        int k;
        int idx;
        logic [1:0] v;
        logic fin;
        logic [1:0] kill;
        logic [15:0] wv;
        logic [17:0] rr;
        int kc;
        mdc_pkg::mdc_chan_t c;
        found = 1'b0;
        kc = int'(s_reg.cur);
        w = 0;
        idx = 0;
        v = 2'h0;
        fin = 1'b0;
        kill = 2'h0;
        wv = 16'h0000;
        rr = 18'h00000;
        c = '0;
        s_next = s_reg;
        s_next.irq = '0;
        for (int i = 0; i < NCH; i++) begin
            fset[i] = 5'h00;
            en = s_reg.gctl[mdc_pkg::G_EN]
                 & s_reg.ch[i].ctrl[mdc_pkg::C_EN]; // see RULE1 RULE11
            code = s_reg.ch[i].trig;
            hwTrig[i] = code != mdc_pkg::TRIG_NONE
                        && code < mdc_pkg::TRIG_UNIMPL
                        && periphEvent[code]; // see RULE13
            if (!en) begin
                s_next.ch[i].busy = 1'b0; // see RULE1 RULE11
            end else if (hwTrig[i] && s_reg.ch[i].busy) begin
                fset[i][mdc_pkg::F_OVR] = 1'b1; // see RULE19
            end else if (!s_reg.ch[i].busy && (hwTrig[i]
                         || s_reg.ch[i].ctrl[mdc_pkg::C_REQ])) begin
                s_next.ch[i].busy = 1'b1; // see RULE6
                s_next.ch[i].flags[mdc_pkg::F_DONE] = 1'b0; // see RULE17
                if (s_reg.ch[i].rArm) begin
                    s_next.ch[i].src = s_reg.ch[i].sSave; // see RULE4 RULE5
                    s_next.ch[i].dst = s_reg.ch[i].dSave;
                    s_next.ch[i].cnt = s_reg.ch[i].cSave;
                    s_next.ch[i].rArm = 1'b0;
                end
            end
            reqV[i] = en & s_reg.ch[i].busy;
        end
        c = s_reg.ch[s_reg.cur];
        case (s_reg.fsm)
            mdc_pkg::ST_IDLE: begin
                for (k = 0; k < NCH; k++) begin
                    idx = s_reg.gctl[mdc_pkg::G_PRS]
                          ? (int'(s_reg.rrBase) + k) % NCH : k; // see RULE2
                    if (!found && reqV[idx]) begin
                        found = 1'b1; // see RULE24
                        w = idx;
                    end
                end
                if (found) begin
                    s_next.cur = CW'(w);
                    s_next.rrBase = CW'((w + 1) % NCH);
                    c = s_reg.ch[w];
                    kc = w;
                    kill = viol(c.src, s_reg.ulim, s_reg.llim); // see RULE16
                    s_next.memWe = 1'b0;
                    s_next.memAddr = c.src;
                    s_next.memBe = laneBe(c.ctrl[mdc_pkg::C_SIZE], c.src[0]);
                    s_next.memReq = kill == 2'h0;
                    s_next.fsm = kill == 2'h0 ? mdc_pkg::ST_READ
                                              : mdc_pkg::ST_IDLE;
                end
            end
            mdc_pkg::ST_READ: begin
                if (memAck) begin
                    s_next.dbuf = c.ctrl[mdc_pkg::C_SIZE]
                        ? {8'h00, c.src[0] ? memRdata[15:8] : memRdata[7:0]}
                        : memRdata; // see RULE26
                    s_next.ch[s_reg.cur].pend = 1'b1; // see RULE12
                    kill = viol(c.dst, s_reg.ulim, s_reg.llim); // see RULE16
                    s_next.memWe = 1'b1;
                    s_next.memAddr = c.dst;
                    s_next.memBe = laneBe(c.ctrl[mdc_pkg::C_SIZE], c.dst[0]);
                    s_next.memWdata = c.ctrl[mdc_pkg::C_SIZE]
                        ? {s_next.dbuf[7:0], s_next.dbuf[7:0]} : s_next.dbuf;
                    s_next.memReq = kill == 2'h0;
                    s_next.fsm = kill == 2'h0 ? mdc_pkg::ST_WRITE
                                              : mdc_pkg::ST_IDLE;
                end
            end
            mdc_pkg::ST_WRITE: begin
                if (memAck && c.ctrl[mdc_pkg::C_NULL_WRITE_MODE]) begin
                    kill = viol(c.src, s_reg.ulim, s_reg.llim); // see RULE3
                    s_next.memAddr = c.src;
                    s_next.memBe = laneBe(c.ctrl[mdc_pkg::C_SIZE], c.src[0]);
                    s_next.memReq = kill == 2'h0;
                    s_next.fsm = kill == 2'h0 ? mdc_pkg::ST_NULL
                                              : mdc_pkg::ST_IDLE;
                end else if (memAck) begin
                    fin = 1'b1;
                end
            end
            mdc_pkg::ST_NULL: begin
                fin = memAck;
            end
            default: s_next.fsm = mdc_pkg::ST_IDLE;
        endcase
        if (kill != 2'h0) begin
            // A source fault in idle belongs to the new winner, not cur.
            s_next.ch[kc].busy = 1'b0; // see RULE23
            s_next.irq[kc] = 1'b1;
            fset[kc][mdc_pkg::F_HIGH] = kill[1];
            fset[kc][mdc_pkg::F_LOW] = ~kill[1];
        end
        if (fin) begin
            s_next.memReq = 1'b0;
            s_next.fsm = mdc_pkg::ST_IDLE;
            s_next.ch[s_reg.cur].pend = 1'b0; // see RULE12
            s_next.ch[s_reg.cur].src = stepPtr(c.src,
                c.ctrl[mdc_pkg::C_SAM +: 2], c.ctrl[mdc_pkg::C_SIZE]); // see RULE7
            s_next.ch[s_reg.cur].dst = stepPtr(c.dst,
                c.ctrl[mdc_pkg::C_DAM +: 2], c.ctrl[mdc_pkg::C_SIZE]); // see RULE8
            s_next.ch[s_reg.cur].cnt = c.cnt - 16'h0001;
            if (c.cnt - 16'h0001 == {1'b0, c.cSave[15:1]}) begin
                fset[s_reg.cur][mdc_pkg::F_HALF] = 1'b1; // see RULE18
                s_next.irq[s_reg.cur] = c.half_irq_enable; // see RULE20
            end
            if (c.cnt == 16'h0001) begin
                fset[s_reg.cur][mdc_pkg::F_DONE] = 1'b1; // see RULE17
                s_next.irq[s_reg.cur] = 1'b1; // see RULE20 RULE21
                s_next.ch[s_reg.cur].ctrl[mdc_pkg::C_REQ] = 1'b0; // see RULE6
                s_next.ch[s_reg.cur].busy = 1'b0;
                s_next.ch[s_reg.cur].rArm = c.ctrl[mdc_pkg::C_RELOAD]
                    | c.ctrl[mdc_pkg::C_TRM + mdc_pkg::TM_REP]; // see RULE4 RULE5
            end else if (!c.ctrl[mdc_pkg::C_TRM + mdc_pkg::TM_CONT]) begin
                s_next.ch[s_reg.cur].busy = 1'b0; // see RULE9 RULE25
            end
        end
        // Dropping a request mid-access is safe only on a bus with no burst.
        if (s_reg.fsm != mdc_pkg::ST_IDLE && !reqV[s_reg.cur]) begin
            s_next.memReq = 1'b0; // see RULE1 RULE11
            s_next.fsm = mdc_pkg::ST_IDLE;
        end
        // Register write: only after both address and data are held.
        if (s_reg.awHeld && s_reg.wHeld && !s_reg.bvalid) begin
            s_next.awHeld = 1'b0;
            s_next.wHeld = 1'b0;
            s_next.bvalid = 1'b1;
            rr = rdFn(s_reg, s_reg.awAddr);
            s_next.bresp = rr[17:16];
            idx = int'(s_reg.awAddr >> mdc_pkg::CH_SHIFT) - 1;
            if (s_reg.awAddr == AW'(mdc_pkg::GCTRL_OFF)) begin
                s_next.gctl = mrg(s_reg.gctl, s_reg.wData, s_reg.wStrb)
                              & mdc_pkg::G_WMASK;
            end else if (s_reg.awAddr == AW'(mdc_pkg::ULIM_OFF)) begin
                s_next.ulim = mrg(s_reg.ulim, s_reg.wData, s_reg.wStrb);
            end else if (s_reg.awAddr == AW'(mdc_pkg::LLIM_OFF)) begin
                s_next.llim = mrg(s_reg.llim, s_reg.wData, s_reg.wStrb);
            end else if (idx >= 0 && idx < NCH) begin
                c = s_next.ch[idx];
                case (s_reg.awAddr[mdc_pkg::CH_SHIFT-1:0])
                    mdc_pkg::CCTRL_OFF: c.ctrl = mrg(c.ctrl, s_reg.wData,
                        s_reg.wStrb) & mdc_pkg::C_WMASK; // see RULE22
                    mdc_pkg::CINT_OFF: begin
                        wv = mrg({c.pend, 1'b0, c.trig, c.flags, 2'h0,
                                  c.half_irq_enable}, s_reg.wData, s_reg.wStrb);
                        c.trig = wv[mdc_pkg::I_SEL +: 6];
                        c.flags = wv[mdc_pkg::I_FLG +: 5]; // see RULE21
                        c.half_irq_enable = wv[mdc_pkg::I_HEN];
                    end
                    mdc_pkg::CSRC_OFF: begin
                        c.src = mrg(c.src, s_reg.wData, s_reg.wStrb);
                        c.sSave = c.src;
                    end
                    mdc_pkg::CDST_OFF: begin
                        c.dst = mrg(c.dst, s_reg.wData, s_reg.wStrb);
                        c.dSave = c.dst;
                    end
                    mdc_pkg::CCNT_OFF: begin
                        c.cnt = mrg(c.cnt, s_reg.wData, s_reg.wStrb);
                        c.cSave = c.cnt;
                    end
                    default: c = s_next.ch[idx];
                endcase
                s_next.ch[idx] = c;
            end
        end
        // Hardware sets are applied last so that they win over a clear.
        for (int i = 0; i < NCH; i++) begin
            s_next.ch[i].flags = s_next.ch[i].flags | fset[i];
        end
        if (s_axi_awvalid && !s_reg.awHeld) begin
            s_next.awHeld = 1'b1;
            s_next.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_reg.wHeld) begin
            s_next.wHeld = 1'b1;
            s_next.wData = s_axi_wdata;
            s_next.wStrb = s_axi_wstrb;
        end
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
        end
        if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end else if (s_axi_arvalid && !s_reg.rvalid) begin
            rr = rdFn(s_reg, s_axi_araddr);
            s_next.rvalid = 1'b1;
            s_next.rdata = rr[15:0];
            s_next.rresp = rr[17:16];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign s_axi_awready = !s_reg.awHeld;
    assign s_axi_wready = !s_reg.wHeld;
    assign s_axi_bvalid = s_reg.bvalid;
    assign s_axi_bresp = s_reg.bresp;
    assign s_axi_arready = !s_reg.rvalid;
    assign s_axi_rvalid = s_reg.rvalid;
    assign s_axi_rresp = s_reg.rresp;
    assign s_axi_rdata = {16'h0000, s_reg.rdata};
    assign memReq = s_reg.memReq;
    assign memWe = s_reg.memWe;
    assign memAddr = s_reg.memAddr;
    assign memWdata = s_reg.memWdata;
    assign memBe = s_reg.memBe;
    assign chanIrq = s_reg.irq;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_write_answer: assert property (s_reg.awHeld && s_reg.wHeld
        && !s_reg.bvalid |=> s_axi_bvalid) // see RULE22
        else $error("write not answered");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid)
        else $error("read not answered");
    a_engine_abort: assert property (!s_reg.gctl[mdc_pkg::G_EN]
        |-> ##1 !memReq ##0 (s_reg.ch[0].busy == 1'b0)) // see RULE1
        else $error("engine off did not abort");
    a_unimpl_code: assert property (s_reg.ch[0].trig >= mdc_pkg::TRIG_UNIMPL
        && !s_reg.ch[0].busy && !s_reg.ch[0].ctrl[mdc_pkg::C_REQ]
        |=> !s_reg.ch[0].busy) // see RULE13
        else $error("unimplemented code triggered");
    a_fixed_lowest: assert property (s_reg.fsm == mdc_pkg::ST_IDLE
        && !s_reg.gctl[mdc_pkg::G_PRS] && reqV[0] |=> s_reg.cur == '0)
        else $error("fixed priority lost by channel 0"); // see RULE24
    a_byte_lane: assert property (memReq
        && s_reg.ch[s_reg.cur].ctrl[mdc_pkg::C_SIZE]
        |-> memBe == (memAddr[0] ? 2'h2 : 2'h1)) // see RULE26
        else $error("byte lane wrong");
    a_pend_write: assert property (s_reg.fsm == mdc_pkg::ST_WRITE
        |-> s_reg.ch[s_reg.cur].pend) // see RULE12
        else $error("pending flag low during write");
    a_overrun_set: assert property (hwTrig[0] && s_reg.ch[0].busy
        && reqV[0] |=> s_reg.ch[0].flags[mdc_pkg::F_OVR]) // see RULE19
        else $error("overrun not flagged");
    a_done_clears: assert property ($rose(s_reg.ch[0].flags[mdc_pkg::F_DONE])
        && !$past(s_reg.awHeld) |-> !s_reg.ch[0].ctrl[mdc_pkg::C_REQ])
        else $error("soft request kept after done"); // see RULE6

    c_null_write: cover property (s_reg.fsm == mdc_pkg::ST_NULL && memAck);
    c_rr_grant: cover property (s_reg.gctl[mdc_pkg::G_PRS] && reqV[0]
        && reqV[1] ##1 s_reg.cur == CW'(1));
    c_half_flag: cover property ($rose(s_reg.ch[0].flags[mdc_pkg::F_HALF]));
    c_limit_kill: cover property ($rose(s_reg.ch[0].flags[mdc_pkg::F_HIGH]));
endmodule // mdc_dma_control

// >>> testbench/mdc_mem_model.sv
// Data-space model that answers the block's accesses.
// Restarts its wait when memReq drops, as the block does when it aborts an access.
`timescale 1ns/1ps
module mdc_mem_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Access request and answer.
    input wire logic memReq,
    input wire logic [15:0] memAddr,
    input wire logic [2:0] lag,
    output logic [15:0] memRdata,
    output logic memAck
);
    logic [2:0] waitCnt;
    // Off the ack cycle the data bus inverts, so a stale sample shows.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            waitCnt <= 3'h0;
            memAck <= 1'b0;
            memRdata <= 16'h0000;
        end else begin
            memAck <= 1'b0;
            memRdata <= ~memRdata;
            if (!memReq || memAck) begin
                waitCnt <= 3'h0;
            end else if (waitCnt >= lag) begin
                memAck <= 1'b1;
                memRdata <= memAddr ^ 16'h5a3c;
            end else begin
                waitCnt <= waitCnt + 3'h1;
            end
        end
    end
endmodule // mdc_mem_model

// >>> testbench/multichannel_dma_control_tb.sv
// Self-checking bench: AXI4-Lite master, write queue model, checks.
// Assumes the memory model returns address xor 5a3c on reads.
`timescale 1ns/1ps
module multichannel_dma_control_tb;
    logic clk = 0, resetn = 0, awV = 0, wV = 0, bRdy = 0, arV = 0, rRdy = 0;
    logic awRdy, wRdy, bV, arRdy, rV, memReq, memWe, memAck;
    logic [11:0] awA = 0, arA = 0;
    logic [31:0] wD = 0, rD, rdVal, seed = 32'h721a1c57, expQ[$];
    logic [1:0] bResp, rResp, memBe, rdResp;
    logic [15:0] memAddr, memWdata, memRdata, rs;
    logic [63:0] events = 0;
    logic [5:0] irq;
    logic [2:0] lag = 0;
    int nErrors = 0, testsRun = 0;
    mdc_dma_control i_dut (.clk(clk), .resetn(resetn), .s_axi_awaddr(awA),
        .s_axi_awvalid(awV), .s_axi_awready(awRdy), .s_axi_wdata(wD),
        .s_axi_wstrb(4'h3), .s_axi_wvalid(wV), .s_axi_wready(wRdy),
        .s_axi_bresp(bResp), .s_axi_bvalid(bV), .s_axi_bready(bRdy),
        .s_axi_araddr(arA), .s_axi_arvalid(arV), .s_axi_arready(arRdy),
        .s_axi_rdata(rD), .s_axi_rresp(rResp), .s_axi_rvalid(rV),
        .s_axi_rready(rRdy), .periphEvent(events), .memReq(memReq),
        .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata), .memBe(memBe),
        .memRdata(memRdata), .memAck(memAck), .chanIrq(irq));
    mdc_mem_model i_mem (.clk(clk), .resetn(resetn), .memReq(memReq),
        .memAddr(memAddr), .lag(lag), .memRdata(memRdata), .memAck(memAck));
    initial forever #10 clk = ~clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    always @(posedge clk) lag <= 3'(rnd());
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        testsRun++;
        if (seen !== exp) begin
            nErrors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic finish_test();
        if (nErrors == 0 && testsRun > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        {awA, wD, awV, wV, bRdy} <= {a, 16'h0000, d, 3'b111};
        do begin
            @(posedge clk);
            if (awRdy) awV <= 1'b0;
            if (wRdy) wV <= 1'b0;
        end while (!bV);
        bRdy <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a);
        {arA, arV, rRdy} <= {a, 2'b11};
        do begin
            @(posedge clk);
            if (arRdy) arV <= 1'b0;
        end while (!rV);
        {rdVal, rdResp} = {rD, rResp};
        rRdy <= 1'b0;
    endtask
    // Every write the block makes must be the next one the model expects.
    always @(posedge clk) if (memReq && memAck && memWe) begin
        if (expQ.size() == 0) chk("extra write", 32'h0, 32'h1);
        else chk("write", {memAddr, memWdata}, expQ.pop_front());
    end
    task automatic run(input int ch, input logic [15:0] ctl, s, d, n,
                       input logic [5:0] trg);
        logic [11:0] b;
        logic [15:0] k, sd, cnt;
        b = 12'(32 * (ch + 1));
        cnt = ctl[3] ? n : 16'h0001;
        for (k = 0; k < cnt; k++) begin
            sd = s + (ctl[7:6] == 2'h1 ? k << 1 : 16'h0);
            expQ.push_back({d + (ctl[5:4] == 2'h1 ? k << 1 : 16'h0),
                            sd ^ 16'h5a3c});
            if (ctl[10]) expQ.push_back({sd, sd ^ 16'h5a3c});
        end
        wr(b + 12'h008, s);
        wr(b + 12'h00c, d);
        wr(b + 12'h010, n);
        wr(b + 12'h004, {2'b00, trg, 8'h00});
        wr(b, ctl);
        events[trg] <= !ctl[8];
        @(posedge clk);
        events <= '0;
        repeat (400) if (expQ.size() != 0) @(posedge clk);
        chk("writes left", expQ.size(), 0);
        repeat (3) @(posedge clk);
        rd(b + 12'h008);
        chk("src", rdVal, s + (ctl[7:6] == 2'h1 ? cnt << 1 : 16'h0));
        rd(b + 12'h010);
        chk("count", rdVal, n - cnt);
        rd(b + 12'h004);
        chk("done", rdVal[5], n == cnt);
        rd(b);
        chk("request", rdVal[8], 1'b0);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        rd(12'h020);
        chk("control reset", rdVal, 32'h0);
        rd(12'h3fc);
        chk("unmapped", rdResp, 2'h2);
        wr(12'h000, 16'h8000);
        wr(12'h004, 16'hffff);
        wr(12'h008, 16'h0800);
        rs = 16'h0900 | 16'(rnd() & 32'h00fe);
        run(0, 16'h0159, rs, 16'h0c00, 16'h0002, 6'h00);
        run(1, 16'h0401, rs, 16'h0d00, 16'h0003, 6'h05);
        wr(12'h004, 16'h0bff);
        events[5] <= 1'b1;
        @(posedge clk);
        events <= '0;
        repeat (20) @(posedge clk);
        rd(12'h044);
        chk("upper flag", rdVal[7], 1'b1);
        finish_test();
    end
    // The whole sequence needs under a thousand cycles; allow thirty times that.
    initial begin
        repeat (30000) @(posedge clk);
        nErrors++;
        finish_test();
    end
endmodule // multichannel_dma_control_tb
